// >>> verilog/pcpwm_sequencer.sv
// Gate drive timing, skip, soft-start and fault sequencing
`timescale 1ns/100ps
module pcpwm_sequencer
    import pcpwm_pkg::*;
#(
    parameter int OVERLOAD_CYCLES  = OVERLOAD_CYC,
    parameter int SOFTSTART_CYCLES = SOFTSTART_CYC
)(
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic clockEnable,
    input  wire logic peakReachedIn,
    input  wire logic peakLimitIn,
    input  wire logic skipLowIn,
    input  wire logic protectHighIn,
    input  wire logic supplyOverIn,
    output logic      gateDriveOutput,
    output logic      softStartActive,
    output logic      overloadError,
    output logic      autoRecovery
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_ff <= 5'h00;
            sync2_ff <= 5'h00;
        end else if (clockEnable) begin
            sync1_ff <= {supplyOverIn, protectHighIn, skipLowIn, peakLimitIn, peakReachedIn};
            sync2_ff <= sync1_ff;
        end
    end
    logic peakReached, peakLimit, skipLow, protectHigh, supplyOver;
    assign {supplyOver, protectHigh, skipLow, peakLimit, peakReached} = sync2_ff;

    // ****************************************
    // State registers
    // ****************************************
    pcpwm_state_type  state_ff, nxt_state;
    logic [CNT_W-1:0] period_ff, nxt_period;
    logic [CNT_W-1:0] blank_ff, nxt_blank;
    logic [CNT_W-1:0] filt_ff, nxt_filt;
    logic [2:0]       fcount_ff, nxt_fcount;
    logic             protSeen_ff, nxt_protSeen;
    logic [CNT_W-1:0] ovp_ff, nxt_ovp;
    logic [CNT_W-1:0] ovl_ff, nxt_ovl;
    logic             err_ff, nxt_err;
    logic [CNT_W-1:0] ss_ff, nxt_ss;
    logic             gate_ff, nxt_gate;
    logic             endPulse;
    logic             filtered;

    always_comb begin
        nxt_state    = state_ff;
        nxt_period   = period_ff;
        nxt_blank    = blank_ff;
        nxt_filt     = filt_ff;
        nxt_fcount   = fcount_ff;
        nxt_protSeen = protSeen_ff;
        nxt_ovp      = ovp_ff;
        nxt_ovl      = ovl_ff;
        nxt_err      = err_ff;
        nxt_ss       = ss_ff;
        nxt_gate     = gate_ff;
        endPulse     = 1'b0;
        filtered     = 1'b0;

        if (period_ff == CNT_W'(PERIOD_CYCLES - 1))
            nxt_period = '0;
        else
            nxt_period = period_ff + 1'b1;

        if (ss_ff != '0)
            nxt_ss = ss_ff - 1'b1;

        // Peak reached ends pulse after blanking
        if (gate_ff && period_ff >= CNT_W'(LEB_CYC) && peakReached)
            endPulse = 1'b1;
        if (gate_ff && period_ff >= CNT_W'(DUTY_CYCLES - 1))
            endPulse = 1'b1;
        if (endPulse) begin
            nxt_gate  = 1'b0;
            nxt_blank = CNT_W'(BLANK_FAULT_CYC);
        end else if (blank_ff != '0) begin
            nxt_blank = blank_ff - 1'b1;
        end

        if (blank_ff != '0 || !protectHigh)
            nxt_filt = '0;
        else if (filt_ff < CNT_W'(FILTER_CYC))
            nxt_filt = filt_ff + 1'b1;
        filtered = (filt_ff >= CNT_W'(FILTER_CYC));
        if (filtered)
            nxt_protSeen = 1'b1;

        if (period_ff == CNT_W'(PERIOD_CYCLES - 1)) begin
            nxt_protSeen = 1'b0;
            if (protSeen_ff || filtered)
                nxt_fcount = fcount_ff + 1'b1;
            else
                nxt_fcount = '0;
        end

        if (!supplyOver)
            nxt_ovp = '0;
        else if (ovp_ff < CNT_W'(OVP_DELAY_CYC))
            nxt_ovp = ovp_ff + 1'b1;

        if (peakLimit && state_ff == PCPWM_RUN) begin
            nxt_err = 1'b1;
            if (!err_ff)
                nxt_ovl = '0;
        end
        if (err_ff && ovl_ff < CNT_W'(OVERLOAD_CYCLES))
            nxt_ovl = ovl_ff + 1'b1;

        case (state_ff)
            PCPWM_RUN: begin
                if (period_ff == CNT_W'(PERIOD_CYCLES - 1) && !skipLow)
                    nxt_gate = 1'b1;
                if ((err_ff && ovl_ff >= CNT_W'(OVERLOAD_CYCLES) && peakLimit)
                        || nxt_fcount >= 3'(FAULT_COUNT)) begin
                    nxt_state = PCPWM_STOPPED;
                    nxt_gate  = 1'b0;
                end else if (ovp_ff >= CNT_W'(OVP_DELAY_CYC)) begin
                    nxt_state = PCPWM_OVP_HICCUP;
                    nxt_gate  = 1'b0;
                end
            end
            PCPWM_OVP_HICCUP: begin
                nxt_gate = 1'b0;
                if (!supplyOver) begin
                    nxt_state = PCPWM_RUN;
                    nxt_ss    = CNT_W'(SOFTSTART_CYCLES);
                end
            end
            default: begin
                // Held until supply lockout reset restarts the part
                nxt_gate = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_ff    <= PCPWM_RUN;
            period_ff   <= '0;
            blank_ff    <= '0;
            filt_ff     <= '0;
            fcount_ff   <= 3'h0;
            protSeen_ff <= 1'b0;
            ovp_ff      <= '0;
            ovl_ff      <= '0;
            err_ff      <= 1'b0;
            ss_ff       <= CNT_W'(SOFTSTART_CYC);
            gate_ff     <= 1'b0;
        end else if (clockEnable) begin
            state_ff    <= nxt_state;
            period_ff   <= nxt_period;
            blank_ff    <= nxt_blank;
            filt_ff     <= nxt_filt;
            fcount_ff   <= nxt_fcount;
            protSeen_ff <= nxt_protSeen;
            ovp_ff      <= nxt_ovp;
            ovl_ff      <= nxt_ovl;
            err_ff      <= nxt_err;
            ss_ff       <= nxt_ss;
            gate_ff     <= nxt_gate;
        end
    end

    assign gateDriveOutput = gate_ff;
    assign softStartActive = (ss_ff != '0);
    assign overloadError   = err_ff;
    assign autoRecovery    = (state_ff != PCPWM_RUN);

    // ****************************************
    // Checks
    // ****************************************
    // Drive low outside run
    a_idle_drive_low: assert property (@(posedge clock) disable iff (!resetn)
        (state_ff != PCPWM_RUN) |=> !gate_ff) else $error("drive high while stopped");
    a_duty_limit: assert property (@(posedge clock) disable iff (!resetn)
        (clockEnable && gate_ff && period_ff == CNT_W'(DUTY_CYCLES - 1)) |=> !gate_ff)
        else $error("pulse beyond duty limit");
    a_start_boundary: assert property (@(posedge clock) disable iff (!resetn)
        $rose(gate_ff) |-> period_ff == '0) else $error("pulse started off boundary");
    a_stop_sticky: assert property (@(posedge clock) disable iff (!resetn)
        (state_ff == PCPWM_STOPPED) |=> (state_ff == PCPWM_STOPPED))
        else $error("left stopped state");
    a_blank_filter: assert property (@(posedge clock) disable iff (!resetn)
        (clockEnable && blank_ff != '0) |=> filt_ff == '0) else $error("filter ran in blank");
    a_skip_blocks: assert property (@(posedge clock) disable iff (!resetn)
        (clockEnable && skipLow && !gate_ff) |=> !gate_ff) else $error("pulse during skip");
    a_leb_mask: assert property (@(posedge clock) disable iff (!resetn)
        (clockEnable && gate_ff && period_ff < CNT_W'(LEB_CYC) && nxt_state == PCPWM_RUN)
        |=> gate_ff) else $error("pulse cut in blank");
    a_error_hold: assert property (@(posedge clock) disable iff (!resetn)
        err_ff |=> err_ff) else $error("error flag dropped");
endmodule : pcpwm_sequencer

// >>> verilog/pcpwm_pkg.sv
// Constants for the peak current PWM protection sequencer
package pcpwm_pkg;
    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int  CLOCK_HZ          = 125_000_000;
    localparam int  SWITCH_HZ         = 65_000;
    localparam int  PERIOD_CYCLES     = CLOCK_HZ / SWITCH_HZ;
    localparam int  MAX_DUTY_PCT      = 80;
    localparam int  DUTY_CYCLES       = PERIOD_CYCLES * MAX_DUTY_PCT / 100;
    localparam int  BLANK_FAULT_NS    = 1000;
    localparam int  BLANK_FAULT_CYC   = BLANK_FAULT_NS * 125 / 1000;
    localparam int  FILTER_NS         = 600;
    localparam int  FILTER_CYC        = (FILTER_NS * 125 + 999) / 1000;
    localparam int  LEB_NS            = 270;
    localparam int  LEB_CYC           = (LEB_NS * 125 + 999) / 1000;
    localparam int  OVP_DELAY_US      = 20;
    localparam int  OVP_DELAY_CYC     = (OVP_DELAY_US * 125);
    localparam int  FAULT_COUNT       = 4;
    localparam int  OVERLOAD_MS       = 115;
    localparam int  OVERLOAD_CYC      = OVERLOAD_MS * 125_000;
    localparam int  SOFTSTART_US      = 4100;
    localparam int  SOFTSTART_CYC     = SOFTSTART_US * 125;
    localparam int  CNT_W             = 24;

    typedef enum logic [1:0] {
        PCPWM_RUN,
        PCPWM_OVP_HICCUP,
        PCPWM_STOPPED
    } pcpwm_state_type;
endpackage : pcpwm_pkg

// >>> verification/pcpwm_sense_model.sv
// Current sense comparator model answering each gate pulse after a set delay
`timescale 1ns/100ps
module pcpwm_sense_model (
    input  wire logic        clock,
    input  wire logic        gateDriveOutput,
    input  wire logic [15:0] peakDelay,
    output logic             peakReachedIn
);
    logic [15:0] onCount;
    initial begin
        onCount       = 16'h0000;
        peakReachedIn = 1'b0;
    end
    // ****************************************
    // Current ramp
    // ****************************************
    // Ramp only while the switch conducts; a large delay never trips
    always @(negedge clock) begin
        if (gateDriveOutput === 1'b1) begin
            onCount       <= onCount + 16'h0001;
            peakReachedIn <= (onCount + 16'h0001 >= peakDelay);
        end else begin
            onCount       <= 16'h0000;
            peakReachedIn <= 1'b0;
        end
    end
endmodule : pcpwm_sense_model

// >>> verification/tb_pcpwm_sequencer.sv
// Self-checking bench for the peak current PWM sequencer
`timescale 1ns/100ps
module tb_pcpwm_sequencer;
    import pcpwm_pkg::*;
    logic        clock, resetn, clockEnable, peakReachedIn, peakLimitIn;
    logic        skipLowIn, protectHighIn, supplyOverIn;
    logic        gateDriveOutput, softStartActive, overloadError, autoRecovery;
    logic [15:0] peakDelay;
    int          err_total, cmp_count, highCycles, falls, rises, r, k;
    int          expQ[$];
    pcpwm_sequencer #(.OVERLOAD_CYCLES(200), .SOFTSTART_CYCLES(50)) pcpwm_sequencer_inst (
        .clock(clock), .resetn(resetn), .clockEnable(clockEnable),
        .peakReachedIn(peakReachedIn), .peakLimitIn(peakLimitIn), .skipLowIn(skipLowIn),
        .protectHighIn(protectHighIn), .supplyOverIn(supplyOverIn),
        .gateDriveOutput(gateDriveOutput), .softStartActive(softStartActive),
        .overloadError(overloadError), .autoRecovery(autoRecovery));
    pcpwm_sense_model pcpwm_sense_model_inst (.clock(clock), .gateDriveOutput(gateDriveOutput),
        .peakDelay(peakDelay), .peakReachedIn(peakReachedIn));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ****************************************
    // Checking and closing
    // ****************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task end_sim;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    task cycles(input int n);
        repeat (n) @(negedge clock);
    endtask : cycles
    task wait_falls(input int n);
        int target;
        int i;
        target = falls + n;
        for (i = 0; i < n * 4000 && falls < target; i++) @(negedge clock);
        if (falls < target) begin
            err_total++;
            $display("unexpected at %0t: gate pulse missing", $time);
            end_sim();
        end
    endtask : wait_falls
    // Pulse width monitor; sampled off the launching edge
    always @(negedge clock) begin
        if (gateDriveOutput === 1'b1) begin
            if (highCycles == 0) rises++;
            highCycles++;
        end else if (highCycles > 0) begin
            falls++;
            if (expQ.size() > 0) check(highCycles, expQ.pop_front());
            highCycles = 0;
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {resetn, peakLimitIn, skipLowIn, protectHighIn, supplyOverIn} = 5'h00;
        clockEnable = 1'b1;
        peakDelay   = 16'hFFFF;
        {err_total, cmp_count} = '0;
        void'($urandom(44941));
        cycles(3);
        check({gateDriveOutput, overloadError, autoRecovery, softStartActive}, 4'h1);
        resetn = 1'b1;
        wait_falls(1);
        repeat (2) expQ.push_back(DUTY_CYCLES);
        wait_falls(2);
        for (k = 0; k < 4; k++) begin
            peakDelay = 16'(40 + $urandom_range(0, 1000));
            // Two-flop input latency adds two clocks
            expQ.push_back(int'(peakDelay) + 2);
            wait_falls(1);
        end
        peakDelay = 16'h0002;
        expQ.push_back(LEB_CYC + 1);
        wait_falls(1);
        // clock enable low freezes the period
        clockEnable = 1'b0;
        r = rises;
        cycles(3 * PERIOD_CYCLES);
        check(rises - r, 0);
        clockEnable = 1'b1;
        peakDelay = 16'h0064;
        skipLowIn = 1'b1;
        r = rises;
        cycles(3 * PERIOD_CYCLES);
        check(rises - r, 0);
        skipLowIn = 1'b0;
        wait_falls(1);
        // a quiet period clears the count
        for (k = 0; k < 2; k++) begin
            protectHighIn = 1'b1;
            cycles(2 * PERIOD_CYCLES);
            protectHighIn = 1'b0;
            // A whole clean period must pass between boundaries
            cycles(2 * PERIOD_CYCLES + 10);
        end
        check(autoRecovery, 1'b0);
        for (k = 0; k < 5; k++) begin
            wait_falls(1);
            cycles(200);
            protectHighIn = 1'b1;
            cycles(40);
            protectHighIn = 1'b0;
        end
        check(autoRecovery, 1'b0);
        protectHighIn = 1'b1;
        cycles(2 * PERIOD_CYCLES);
        check(autoRecovery, 1'b0);
        cycles(4 * PERIOD_CYCLES);
        check({autoRecovery, gateDriveOutput}, 2'b10);
        protectHighIn = 1'b0;
        r = rises;
        cycles(2 * PERIOD_CYCLES);
        check({autoRecovery, 31'(rises - r)}, {1'b1, 31'h0});
        resetn = 1'b0;
        cycles(3);
        check({autoRecovery, softStartActive}, 2'b01);
        resetn = 1'b1;
        wait_falls(1);
        supplyOverIn = 1'b1;
        cycles(OVP_DELAY_CYC - 200);
        check(autoRecovery, 1'b0);
        supplyOverIn = 1'b0;
        cycles(10);
        supplyOverIn = 1'b1;
        cycles(OVP_DELAY_CYC - 10);
        check(autoRecovery, 1'b0);
        cycles(20);
        check({autoRecovery, gateDriveOutput}, 2'b10);
        supplyOverIn = 1'b0;
        cycles(10);
        check({autoRecovery, softStartActive}, 2'b01);
        cycles(70);
        check(softStartActive, 1'b0);
        wait_falls(1);
        peakLimitIn = 1'b1;
        cycles(10);
        check(overloadError, 1'b1);
        cycles(150);
        check(autoRecovery, 1'b0);
        cycles(100);
        check(autoRecovery, 1'b1);
        end_sim();
    end
endmodule : tb_pcpwm_sequencer
